//--- design/flash_bus_cycle.v
`timescale 1ns/1ps
`include "flash_status_defs.vh"

// one asynchronous bus cycle: read (output strobe) or write (write strobe)
module flash_bus_cycle
(
  input wire mclk,
  input wire rst_n,
  input wire start,
  input wire write,
  input wire [20:0] addr,
  input wire [7:0] wdata,
  input wire [7:0] dq_in_s,
  output reg done_q,
  output reg [7:0] rdata_q,
  output reg ce_n_q,
  output reg oe_n_q,
  output reg we_n_q,
  output reg [20:0] addr_q,
  output reg [7:0] dq_out_q,
  output reg dq_oe_q
);

  localparam S_IDLE = 2'h0;
  localparam S_LOW = 2'h1;
  localparam S_WAIT = 2'h2;
  localparam S_HIGH = 2'h3;
  localparam integer LOW_END_I = `STROBE_LOW_CYC + 2;
  localparam integer HIGH_END_I = `STROBE_HIGH_CYC;
  // both counts stay far below 32, so five bits hold them whole
  localparam [4:0] LOW_END = LOW_END_I[4:0];
  localparam [4:0] HIGH_END = HIGH_END_I[4:0];

  reg [1:0] st_q;
  reg [4:0] cnt_q;
  reg wr_q;

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= S_IDLE;
      cnt_q <= 5'h0;
      wr_q <= 1'b0;
      done_q <= 1'b0;
      rdata_q <= 8'h0;
      ce_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      addr_q <= 21'h0;
      dq_out_q <= 8'h0;
      dq_oe_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      case (st_q)
        S_IDLE:
        begin
          if (start)
          begin
            wr_q <= write;
            addr_q <= addr;
            dq_out_q <= wdata;
            dq_oe_q <= write;
            ce_n_q <= 1'b0;
            oe_n_q <= write;
            we_n_q <= ~write;
            cnt_q <= 5'h0;
            st_q <= S_LOW;
          end
        end
        S_LOW:
        begin
          // the synchroniser adds two cycles; wait them out before capturing
          if (cnt_q == LOW_END)
          begin
            if (!wr_q)
              rdata_q <= dq_in_s;
            // each completed read cycle while the device is busy is one toggle step on the device side
            ce_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
            cnt_q <= 5'h0;
            st_q <= S_WAIT;
          end
          else
            cnt_q <= cnt_q + 5'h1;
        end
        S_WAIT:
        begin
          dq_oe_q <= 1'b0;
          st_q <= S_HIGH;
        end
        S_HIGH:
        begin
          if (cnt_q == HIGH_END)
          begin
            done_q <= 1'b1;
            st_q <= S_IDLE;
          end
          else
            cnt_q <= cnt_q + 5'h1;
        end
        default:
          st_q <= S_IDLE;
      endcase
    end
  end

endmodule // flash_bus_cycle

//--- design/flash_status_defs.vh
`ifndef FLASH_STATUS_DEFS_VH
`define FLASH_STATUS_DEFS_VH

// status byte bit positions
`define DATA_POLL_POS 7
`define PROGRESS_TOGGLE_POS 6
`define TIME_LIMIT_POS 5
`define ERASE_WINDOW_POS 3
`define SECTOR_TOGGLE_POS 2

// bus cycle timing, in ns and derived mclk cycles (200 MHz)
`define CLK_PERIOD_NS 5
`define STROBE_LOW_NS 70
`define STROBE_LOW_CYC ((`STROBE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_HIGH_NS 30
`define STROBE_HIGH_CYC ((`STROBE_HIGH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// sector load window, longest time rounds down
`define SECTOR_LOAD_NS 50000
`define SECTOR_LOAD_CYC (`SECTOR_LOAD_NS / `CLK_PERIOD_NS)

// reset command sequence data
`define RESET_CMD_DATA 8'hf0
// erase suspend command data
`define SUSPEND_CMD_DATA 8'hb0

// result codes
`define RES_DONE 2'h0
`define RES_FAIL 2'h1
`define RES_ERASING 2'h2
`define RES_SUSPENDED 2'h3

`endif

//--- design/flash_status_poller.v
`timescale 1ns/1ps
`include "flash_status_defs.vh"

module flash_status_poller
(
  input wire mclk,
  input wire rst_n,
  // user side
  input wire poll_start,
  input wire [20:0] poll_addr,
  input wire check_window,
  input wire wr_start,
  input wire [20:0] wr_addr,
  input wire [7:0] wr_data,
  input wire abort,
  output reg busy_q,
  output reg result_valid_q,
  output reg [1:0] result_q,
  output reg [7:0] status_byte_q,
  output reg window_was_open_q,
  output reg window_closed_after_q,
  output reg device_ready_q,
  // flash pins
  output reg ce_n_q,
  output reg oe_n_q,
  output reg we_n_q,
  output reg [20:0] addr_q,
  input wire [7:0] dq_in,
  output reg [7:0] dq_out_q,
  output reg dq_oe_q,
  input wire ready_busy_out
);

  localparam P_IDLE = 3'h0;
  localparam P_FIRST = 3'h1;
  localparam P_SECOND = 3'h2;
  localparam P_RECHECK = 3'h3;
  localparam P_RESET = 3'h4;
  localparam P_WIN_PRE = 3'h5;
  localparam P_WRITE = 3'h6;
  localparam P_WIN_POST = 3'h7;
  localparam integer LOAD_END_I = `SECTOR_LOAD_CYC;
  // the load window count fits the fourteen-bit gap counter
  localparam [13:0] LOAD_END = LOAD_END_I[13:0];

  function toggled;
    input [7:0] a;
    input [7:0] b;
    begin
      toggled = a[`PROGRESS_TOGGLE_POS] ^ b[`PROGRESS_TOGGLE_POS];
    end
  endfunction

  reg [7:0] dq_m_q;
  reg [7:0] dq_s_q;
  reg rb_m_q;
  reg rb_s_q;
  reg [2:0] st_q;
  reg [7:0] prev_q;
  reg wait_q;
  reg cyc_start;
  reg cyc_write;
  reg [20:0] cyc_addr;
  reg [7:0] cyc_data;
  wire cyc_done;
  wire [7:0] cyc_rdata;
  wire b_ce_n;
  wire b_oe_n;
  wire b_we_n;
  wire [20:0] b_addr;
  wire [7:0] b_dq;
  wire b_dq_oe;
  reg [20:0] addr_hold_q;
  reg [13:0] gap_q;

  // dq and ready/busy come from the device pins: two flops first;
  // pin outputs are re-registered here so the top outputs come from flops
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dq_m_q <= 8'h0;
      dq_s_q <= 8'h0;
      rb_m_q <= 1'b1;
      rb_s_q <= 1'b1;
      ce_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      addr_q <= 21'h0;
      dq_out_q <= 8'h0;
      dq_oe_q <= 1'b0;
      device_ready_q <= 1'b1;
    end
    else
    begin
      dq_m_q <= dq_in;
      dq_s_q <= dq_m_q;
      rb_m_q <= ready_busy_out;
      rb_s_q <= rb_m_q;
      ce_n_q <= b_ce_n;
      oe_n_q <= b_oe_n;
      we_n_q <= b_we_n;
      addr_q <= b_addr;
      dq_out_q <= b_dq;
      dq_oe_q <= b_dq_oe;
      device_ready_q <= rb_s_q;
    end
  end

  flash_bus_cycle u_cycle
  (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(cyc_start),
    .write(cyc_write),
    .addr(cyc_addr),
    .wdata(cyc_data),
    .dq_in_s(dq_s_q),
    .done_q(cyc_done),
    .rdata_q(cyc_rdata),
    .ce_n_q(b_ce_n),
    .oe_n_q(b_oe_n),
    .we_n_q(b_we_n),
    .addr_q(b_addr),
    .dq_out_q(b_dq),
    .dq_oe_q(b_dq_oe)
  );

  always @*
  begin
    cyc_start = 1'b0;
    cyc_write = 1'b0;
    cyc_addr = addr_hold_q;
    cyc_data = 8'h0;
    if (!wait_q)
    begin
      case (st_q)
        // every status read uses the caller's address, in an erased sector for the sector toggle
        P_FIRST, P_SECOND, P_RECHECK, P_WIN_PRE, P_WIN_POST:
          cyc_start = 1'b1;
        P_RESET, P_WRITE:
        begin
          cyc_start = 1'b1;
          cyc_write = 1'b1;
          cyc_data = (st_q == P_RESET) ? `RESET_CMD_DATA : wr_data;
        end
        default:
          cyc_start = 1'b0;
      endcase
    end
  end

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= P_IDLE;
      prev_q <= 8'h0;
      wait_q <= 1'b0;
      addr_hold_q <= 21'h0;
      gap_q <= 14'h0;
      busy_q <= 1'b0;
      result_valid_q <= 1'b0;
      result_q <= `RES_DONE;
      status_byte_q <= 8'h0;
      window_was_open_q <= 1'b0;
      window_closed_after_q <= 1'b0;
    end
    else
    begin
      result_valid_q <= 1'b0;
      if (cyc_start)
        wait_q <= 1'b1;
      else if (cyc_done)
        wait_q <= 1'b0;
      // load window runs from the end of the last write; reset counts as a fresh start
      if (gap_q != LOAD_END)
        gap_q <= gap_q + 14'h1;
      case (st_q)
        P_IDLE:
        begin
          busy_q <= 1'b0;
          // a new poll always begins at the first read
          if (poll_start && !busy_q)
          begin
            addr_hold_q <= poll_addr;
            busy_q <= 1'b1;
            st_q <= P_FIRST;
          end
          else if (wr_start && !busy_q)
          begin
            addr_hold_q <= wr_addr;
            busy_q <= 1'b1;
            st_q <= check_window ? P_WIN_PRE : P_WRITE;
          end
        end
        P_FIRST:
          if (cyc_done)
          begin
            prev_q <= cyc_rdata;
            st_q <= P_SECOND;
          end
        P_SECOND:
          if (cyc_done)
          begin
            status_byte_q <= cyc_rdata;
            prev_q <= cyc_rdata;
            if (!toggled(prev_q, cyc_rdata))
            begin
              result_q <= `RES_DONE;
              result_valid_q <= 1'b1;
              st_q <= P_IDLE;
            end
            else if (cyc_rdata[`TIME_LIMIT_POS])
              st_q <= P_RECHECK;
            else if (abort)
            begin
              // leaving: the next poll must restart from the first read
              // progress still toggles, so the device is working, not suspended
              result_q <= `RES_ERASING;
              result_valid_q <= 1'b1;
              st_q <= P_IDLE;
            end
            else
              st_q <= P_SECOND;
          end
        P_RECHECK:
          if (cyc_done)
          begin
            status_byte_q <= cyc_rdata;
            if (!toggled(prev_q, cyc_rdata))
            begin
              result_q <= `RES_DONE;
              result_valid_q <= 1'b1;
              st_q <= P_IDLE;
            end
            else
              st_q <= P_RESET;
          end
        P_RESET:
          if (cyc_done)
          begin
            // only status works until this reset command is written
            result_q <= `RES_FAIL;
            result_valid_q <= 1'b1;
            st_q <= P_IDLE;
          end
        P_WIN_PRE:
          if (cyc_done)
          begin
            status_byte_q <= cyc_rdata;
            // a sector added after the load window lapsed counts as not open
            window_was_open_q <= ~cyc_rdata[`ERASE_WINDOW_POS] & (gap_q != LOAD_END);
            st_q <= P_WRITE;
          end
        P_WRITE:
          if (cyc_done)
          begin
            gap_q <= 14'h0;
            if (check_window)
              st_q <= P_WIN_POST;
            else
            begin
              result_q <= `RES_DONE;
              result_valid_q <= 1'b1;
              st_q <= P_IDLE;
            end
          end
        P_WIN_POST:
          if (cyc_done)
          begin
            status_byte_q <= cyc_rdata;
            // high afterwards: the added sector may not have been taken
            window_closed_after_q <= cyc_rdata[`ERASE_WINDOW_POS];
            result_q <= cyc_rdata[`ERASE_WINDOW_POS] ? `RES_FAIL : `RES_DONE;
            result_valid_q <= 1'b1;
            st_q <= P_IDLE;
          end
        default:
          st_q <= P_IDLE;
      endcase
    end
  end

endmodule // flash_status_poller

//--- verif/flash_dev_model.sv
`timescale 1ns/1ps
`include "flash_status_defs.vh"
module flash_dev_model
(
  input wire ce_n,
  input wire oe_n,
  input wire we_n,
  input wire [20:0] addr,
  input wire [7:0] dq_out,
  output wire [7:0] dq_in,
  output wire ready_busy_out
);
  localparam [4:0] ERASE_SECTOR = 5'h01;
  localparam [7:0] ARRAY_BYTE = 8'h5a;
  int busy_reads = 0;
  logic time_limit = 1'b0;
  logic window = 1'b0;
  logic suspended = 1'b0;
  logic tog_q = 1'b0;
  logic sec_q = 1'b0;
  logic [7:0] last = 8'h00;
  logic [7:0] wd = 8'h00;
  logic [20:0] seen_addr = 21'h0;
  wire rd = !ce_n && !oe_n;
  wire wr = !ce_n && !we_n;
  wire in_sector = addr[20:16] == ERASE_SECTOR;
  wire [7:0] run_stat = {busy_reads == 0, tog_q, time_limit, 1'b0, window, sec_q, 2'b00};
  // suspended: erased sector shows poll 1, frozen progress, flag 0; other sectors read array data
  wire [7:0] susp_stat = in_sector ? {1'b1, tog_q, 1'b0, 1'b0, window, sec_q, 2'b00} : ARRAY_BYTE;
  wire [7:0] stat = suspended ? susp_stat : run_stat;
  // released bus shows the inverse of the last byte so stale data cannot pass
  assign dq_in = rd ? stat : ~last;
  assign ready_busy_out = busy_reads == 0 || suspended;
  always @(negedge rd)
  begin
    last = stat;
    seen_addr = addr;
    if (suspended)
    begin
      if (in_sector)
        sec_q = ~sec_q;
    end
    else if (busy_reads > 0)
    begin
      tog_q = ~tog_q;
      sec_q = ~sec_q;
      if (!time_limit)
        busy_reads = busy_reads - 1;
    end
  end
  always @(dq_out or wr)
    if (wr)
      wd = dq_out;
  always @(negedge wr)
  begin
    seen_addr = addr;
    if (wd == `RESET_CMD_DATA)
    begin
      busy_reads = 0;
      time_limit = 1'b0;
      suspended = 1'b0;
    end
    else if (wd == `SUSPEND_CMD_DATA && busy_reads > 0)
      suspended = 1'b1;
  end
  // other writes while window is high are dropped, nothing to model otherwise
endmodule // flash_dev_model

//--- verif/flash_write_status_reporting_test.sv
`timescale 1ns/1ps
`include "flash_status_defs.vh"
module flash_write_status_reporting_test;
  reg mclk = 0, rst_n = 0, poll_start = 0, check_window = 0, wr_start = 0, abort = 0;
  reg [20:0] poll_addr = 21'h010000, wr_addr = 21'h01a5a5;
  reg [7:0] wr_data = 8'h30;
  wire busy_q, result_valid_q, window_was_open_q, window_closed_after_q, device_ready_q;
  wire ce_n_q, oe_n_q, we_n_q, dq_oe_q, ready_busy_out;
  wire [1:0] result_q;
  wire [7:0] status_byte_q, dq_in, dq_out_q;
  wire [20:0] addr_q;
  integer failures = 0, check_count = 0, cycles = 0;
  flash_status_poller DUT (.mclk(mclk), .rst_n(rst_n), .poll_start(poll_start), .poll_addr(poll_addr),
    .check_window(check_window), .wr_start(wr_start), .wr_addr(wr_addr), .wr_data(wr_data), .abort(abort),
    .busy_q(busy_q), .result_valid_q(result_valid_q), .result_q(result_q), .status_byte_q(status_byte_q),
    .window_was_open_q(window_was_open_q), .window_closed_after_q(window_closed_after_q),
    .device_ready_q(device_ready_q), .ce_n_q(ce_n_q), .oe_n_q(oe_n_q), .we_n_q(we_n_q), .addr_q(addr_q),
    .dq_in(dq_in), .dq_out_q(dq_out_q), .dq_oe_q(dq_oe_q), .ready_busy_out(ready_busy_out));
  flash_dev_model dev (.ce_n(ce_n_q), .oe_n(oe_n_q), .we_n(we_n_q), .addr(addr_q), .dq_out(dq_out_q), .dq_in(dq_in),
    .ready_busy_out(ready_busy_out));
  initial forever #2.5 mclk = ~mclk;
  task check(input [7:0] got, input [7:0] exp, input string what);
    begin
      check_count = check_count + 1;
      if (got !== exp)
      begin
        failures = failures + 1;
        $display("unexpected at %0t: %0s got %h want %h", $time, what, got, exp);
      end
    end
  endtask
  task test_done;
    begin
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  always @(posedge mclk)
  begin
    cycles = cycles + 1;
    if (cycles == 15000)
    begin
      failures = failures + 1;
      test_done;
    end
  end
  // p high: toggle poll, low: write, window-checked only while check_window is set
  task run(input p, input [1:0] exp);
    begin
      @(posedge mclk);
      #1;
      poll_start = p;
      wr_start = !p;
      @(posedge mclk);
      #1;
      poll_start = 0;
      wr_start = 0;
      // no local limit: a hang runs into the cycle ceiling and fails there
      while (result_valid_q !== 1'b1)
      begin
        @(posedge mclk);
        #1;
      end
      check({6'h00, result_q}, {6'h00, exp}, "result");
      $display("test ended at %0t", $time);
    end
  endtask
  initial
  begin
    repeat (5) @(posedge mclk);
    #1;
    rst_n = 1;
    run(1'b1, `RES_DONE);
    check({7'h00, status_byte_q[`DATA_POLL_POS]}, 8'h01, "poll bit");
    dev.busy_reads = 6;
    run(1'b1, `RES_DONE);
    check(dev.busy_reads[7:0], 8'h00, "reads left");
    check({7'h00, device_ready_q}, 8'h01, "ready");
    dev.time_limit = 1'b1;
    dev.busy_reads = 50;
    repeat (4) @(posedge mclk);
    #1;
    check({7'h00, device_ready_q}, 8'h00, "busy seen");
    run(1'b1, `RES_FAIL);
    check({7'h00, status_byte_q[`TIME_LIMIT_POS]}, 8'h01, "limit flag");
    check(dev.busy_reads[7:0], 8'h00, "reset taken");
    abort = 1'b1;
    dev.busy_reads = 50;
    run(1'b1, `RES_ERASING);
    abort = 1'b0;
    dev.busy_reads = 0;
    check_window = 1'b1;
    run(1'b0, `RES_DONE);
    check({6'h00, window_was_open_q, window_closed_after_q}, 8'h02, "window open");
    check(dev.seen_addr[7:0], 8'ha5, "write address");
    dev.window = 1'b1;
    run(1'b0, `RES_FAIL);
    check({7'h00, window_closed_after_q}, 8'h01, "window shut");
    dev.window = 1'b0;
    // wait past the sector load window before adding a sector
    repeat (10010) @(posedge mclk);
    run(1'b0, `RES_DONE);
    check({6'h00, window_was_open_q, window_closed_after_q}, 8'h00, "late load");
    check_window = 1'b0;
    wr_data = `SUSPEND_CMD_DATA;
    dev.busy_reads = 50;
    run(1'b0, `RES_DONE);
    check({7'h00, dev.suspended}, 8'h01, "suspended");
    run(1'b1, `RES_DONE);
    check({6'h00, status_byte_q[`DATA_POLL_POS], status_byte_q[`TIME_LIMIT_POS]}, 8'h02, "suspend status");
    check({7'h00, device_ready_q}, 8'h01, "ready in suspend");
    poll_addr = 21'h0a5a5a;
    run(1'b1, `RES_DONE);
    check(status_byte_q, 8'h5a, "array data");
    check(dev.seen_addr[15:8], 8'h5a, "read address");
    test_done;
  end
endmodule // flash_write_status_reporting_test

//--- verif/poller_properties.sv
`timescale 1ns/1ps
`include "flash_status_defs.vh"
module poller_checker
(
  input wire mclk,
  input wire rst_n,
  input wire poll_start,
  input wire wr_start,
  input wire busy_q,
  input wire result_valid_q,
  input wire [1:0] result_q,
  input wire ce_n_q,
  input wire oe_n_q,
  input wire we_n_q,
  input wire [20:0] addr_q,
  input wire [7:0] dq_out_q,
  input wire dq_oe_q,
  input wire ready_busy_out,
  input wire device_ready_q
);
  reg in_poll_q;
  reg f0_seen_q;
  reg [3:0] reads_q;
  // reads saturate: only "at least two" matters
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      in_poll_q <= 1'b0;
      f0_seen_q <= 1'b0;
      reads_q <= 4'h0;
    end
    else if (!busy_q && (poll_start || wr_start))
    begin
      in_poll_q <= poll_start;
      f0_seen_q <= 1'b0;
      reads_q <= 4'h0;
    end
    else
    begin
      if (!we_n_q && dq_oe_q && dq_out_q == `RESET_CMD_DATA)
        f0_seen_q <= 1'b1;
      if ($rose(oe_n_q) && reads_q != 4'hf)
        reads_q <= reads_q + 4'h1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_strobe_needs_select: assert property ((!oe_n_q || !we_n_q) |-> !ce_n_q)
    else $error("strobe low without chip select");
  a_no_bus_fight: assert property (dq_oe_q |-> oe_n_q)
    else $error("data driven during read");
  a_addr_held_read: assert property (!oe_n_q && $past(!oe_n_q) |-> $stable(addr_q))
    else $error("address moved during read");
  a_write_data_held: assert property (!we_n_q && $past(!we_n_q) |-> dq_oe_q && $stable(dq_out_q))
    else $error("write data not held");
  a_two_reads_first: assert property (result_valid_q && in_poll_q |-> reads_q >= 4'h2)
    else $error("poll ended before two reads");
  a_fail_resets: assert property (result_valid_q && in_poll_q && result_q == `RES_FAIL |-> f0_seen_q)
    else $error("fail without reset command");
  a_done_no_reset: assert property (result_valid_q && in_poll_q && result_q == `RES_DONE |-> !f0_seen_q)
    else $error("reset command on a good finish");
  a_result_pulse: assert property (result_valid_q |=> !result_valid_q)
    else $error("result strobe too long");
  a_start_busy: assert property ((poll_start || wr_start) && !busy_q |=> busy_q)
    else $error("request not taken");
  a_ready_follows: assert property ($rose(ready_busy_out) |-> ##[1:4] device_ready_q)
    else $error("ready not seen");
endmodule // poller_checker
bind flash_status_poller poller_checker chk (.mclk(mclk), .rst_n(rst_n), .poll_start(poll_start),
  .wr_start(wr_start), .busy_q(busy_q), .result_valid_q(result_valid_q), .result_q(result_q), .ce_n_q(ce_n_q),
  .oe_n_q(oe_n_q), .we_n_q(we_n_q), .addr_q(addr_q), .dq_out_q(dq_out_q), .dq_oe_q(dq_oe_q),
  .ready_busy_out(ready_busy_out), .device_ready_q(device_ready_q));
